// ---- pkg/rcw_pkg.sv ----
// constants, register map and encodings of the ring conditional-write and receiver status block
// Function
// [RL1] event latch read loads compare register
// [RL2] software writes compare register directly
// [RL3] conditional write changes only bits matching compare
// [RL4] status tracks receiver, steady during access
// [RL5] status readable always, writes discarded
// [RL6] diagnose mode freezes status until error cleared
// [RL7] bit 7 reports restricted token flag
// [RL8] bits 6-4 receive state, listen zero
// [RL9] bits 2-0 receive timing state codes
// [RL10] bit 3 reserved, reads zero
// [RL11] remaining receive state codes in order
package rcw_pkg;

  // ==========================================================
  // bus and register map
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_EVT = 12'h000;
  localparam logic [11:0] ADDR_INT = 12'h004;
  localparam logic [11:0] ADDR_STAT = 12'h00c;
  localparam logic [11:0] ADDR_CMP = 12'h010;
  localparam logic [11:0] ADDR_CTRL = 12'h014;
  localparam logic [11:0] ADDR_ISTAT = 12'h018;
  localparam logic [11:0] ADDR_IMASK = 12'h01c;
  localparam int SEL_BIT = 8;

  // ==========================================================
  // reset values and field positions
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam int CTRL_DIAG_BIT = 0;
  localparam int INT_RXERR_BIT = 0;
  localparam int IRQ_EVT_BIT = 0;
  localparam int IRQ_INT_BIT = 1;
  localparam int IRQ_FRZ_BIT = 2;
  localparam int STAT_RESTRICTED_TOKEN_FLAG_BIT = 7;
  localparam int STAT_RS_LSB = 4;
  localparam int STAT_RES_BIT = 3;
  localparam int STAT_RTS_LSB = 0;

  // ==========================================================
  // encodings
  typedef enum logic [2:0] {
    REG_EVT = 3'b000,
    REG_INT = 3'b001,
    REG_STAT = 3'b010,
    REG_CMP = 3'b011,
    REG_CTRL = 3'b100,
    REG_ISTAT = 3'b101,
    REG_IMASK = 3'b110,
    REG_NONE = 3'b111
  } rcw_reg_e;

  typedef enum logic [2:0] {
    RX_LISTEN = 3'b000,
    RX_AWAIT_SD = 3'b001,
    RX_FRAME_CTRL = 3'b010,
    RX_FRAME_BODY = 3'b011,
    RX_AC_IND = 3'b100,
    RX_CHECK_TOKEN = 3'b101,
    RX_OPT_IND = 3'b110,
    RX_RESERVED = 3'b111
  } rcw_rx_state_e;

  typedef enum logic [2:0] {
    RT_AWAIT_SD = 3'b000,
    RT_CHECK_FC = 3'b001,
    RT_CHECK_SA = 3'b010,
    RT_CHECK_DA = 3'b011,
    RT_CHECK_INFO = 3'b100,
    RT_CHECK_MAC = 3'b101,
    RT_RES6 = 3'b110,
    RT_RES7 = 3'b111
  } rcw_rx_timing_e;

endpackage : rcw_pkg

// ---- pkg/rcw_stat_if.sv ----
// link between register logic and the receiver status capture
`timescale 1ns/1ps
interface rcw_stat_if;
  logic hold;
  logic diag;
  logic err_bit;
  logic [7:0] status;

  modport regs (
    output hold,
    output diag,
    output err_bit,
    input status
  );

  modport stat (
    input hold,
    input diag,
    input err_bit,
    output status
  );
endinterface : rcw_stat_if

// ---- hw/rcw_rx_status.sv ----
// receiver status capture with access hold and diagnose freeze
`timescale 1ns/1ps
module rcw_rx_status
  import rcw_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // receiver machines
  input wire logic rx_restricted,
  input wire logic [2:0] rx_state,
  input wire logic [2:0] rx_timing,
  // register side
  rcw_stat_if.stat sb
);

  rcw_rx_state_e rx_frame_state;
  rcw_rx_timing_e rx_time_state;
  logic [7:0] next_status;
  logic freeze;

  assign rx_frame_state = rcw_rx_state_e'(rx_state);
  assign rx_time_state = rcw_rx_timing_e'(rx_timing);

  // ==========================================================
  // packing
  always_comb
  begin
    next_status = RST_BYTE;
    next_status[STAT_RESTRICTED_TOKEN_FLAG_BIT] = rx_restricted; // RL7
    next_status[STAT_RS_LSB +: 3] = rx_frame_state; // RL8 RL11
    next_status[STAT_RES_BIT] = 1'b0; // RL10
    next_status[STAT_RTS_LSB +: 3] = rx_time_state; // RL9
  end

  // ==========================================================
  // capture
  assign freeze = sb.diag & sb.err_bit; // RL6

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sb.status <= RST_BYTE;
    else if (!(sb.hold || freeze)) // RL4 RL6
      sb.status <= next_status;
  end

endmodule : rcw_rx_status

// ---- hw/rcw_top.sv ----
// apb register bank: conditional-write event latches, compare register, receiver status
`timescale 1ns/1ps
module rcw_top
  import rcw_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // event sources, one-cycle set pulses
  input wire logic [7:0] evt_set,
  input wire logic [7:0] int_evt_set,
  // receiver machines
  input wire logic rx_restricted,
  input wire logic [2:0] rx_state,
  input wire logic [2:0] rx_timing,
  // interrupt
  output logic irq
);

  // ==========================================================
  // decode
  function automatic rcw_reg_e reg_decode(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] base;
    base = a;
    base[SEL_BIT] = 1'b0;
    reg_decode = REG_NONE;
    if (base == ADDR_EVT)
      reg_decode = REG_EVT;
    else if (base == ADDR_INT)
      reg_decode = REG_INT;
    else if (a == ADDR_STAT)
      reg_decode = REG_STAT;
    else if (a == ADDR_CMP)
      reg_decode = REG_CMP;
    else if (a == ADDR_CTRL)
      reg_decode = REG_CTRL;
    else if (a == ADDR_ISTAT)
      reg_decode = REG_ISTAT;
    else if (a == ADDR_IMASK)
      reg_decode = REG_IMASK;
  endfunction : reg_decode

  // bit takes new value only where current equals compare
  function automatic logic [7:0] cond_merge(
    input logic [7:0] cur,
    input logic [7:0] cmpv,
    input logic [7:0] wd
  );
    logic [7:0] m;
    m = ~(cur ^ cmpv);
    cond_merge = (cur & ~m) | (wd & m);
  endfunction : cond_merge

  // ==========================================================
  // bus phases
  rcw_reg_e sel;
  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic cond;
  logic latch_hit;

  assign sel = reg_decode(paddr);
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  assign cond = ~paddr[SEL_BIT];
  assign latch_hit = (sel == REG_EVT) | (sel == REG_INT);
  assign pready = access;
  assign pslverr = access & (sel == REG_NONE);

  // ==========================================================
  // registers
  logic [7:0] evt;
  logic [7:0] int_evt;
  logic [7:0] cmp;
  logic [7:0] ctrl;
  logic [7:0] irq_stat;
  logic [7:0] irq_mask;
  logic [7:0] next_evt;
  logic [7:0] next_int_evt;
  logic [7:0] next_irq_stat;
  logic [7:0] irq_ev;
  logic [7:0] read_mux;

  rcw_stat_if sb ();

  rcw_rx_status u_stat (
    .pclk(pclk),
    .presetn(presetn),
    .rx_restricted(rx_restricted),
    .rx_state(rx_state),
    .rx_timing(rx_timing),
    .sb(sb.stat)
  );

  // status is held from setup through access of its own read
  assign sb.hold = psel & (sel == REG_STAT); // RL4
  assign sb.diag = ctrl[CTRL_DIAG_BIT];
  assign sb.err_bit = int_evt[INT_RXERR_BIT]; // RL6

  // ==========================================================
  // event latches: hardware set beats a simultaneous clear
  always_comb
  begin
    next_evt = evt;
    if (wr && sel == REG_EVT)
      next_evt = cond ? cond_merge(evt, cmp, pwdata[7:0]) : pwdata[7:0]; // RL3
    next_evt = next_evt | evt_set;
  end

  always_comb
  begin
    next_int_evt = int_evt;
    if (wr && sel == REG_INT)
      next_int_evt = cond ? cond_merge(int_evt, cmp, pwdata[7:0]) : pwdata[7:0]; // RL3
    next_int_evt = next_int_evt | int_evt_set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      evt <= RST_BYTE;
    else
      evt <= next_evt;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_evt <= RST_BYTE;
    else
      int_evt <= next_int_evt;
  end

  // ==========================================================
  // compare register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cmp <= RST_BYTE;
    else if (wr && sel == REG_CMP)
      cmp <= pwdata[7:0]; // RL2
    else if (rd && latch_hit)
      cmp <= prdata[7:0]; // RL1
  end

  // ==========================================================
  // control and mask
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl <= RST_BYTE;
    else if (wr && sel == REG_CTRL)
      ctrl <= {7'h00, pwdata[CTRL_DIAG_BIT]};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask <= RST_BYTE;
    else if (wr && sel == REG_IMASK)
      irq_mask <= pwdata[7:0];
  end

  // ==========================================================
  // interrupt status, cleared by read, set wins
  always_comb
  begin
    irq_ev = RST_BYTE;
    irq_ev[IRQ_EVT_BIT] = |evt_set;
    irq_ev[IRQ_INT_BIT] = |int_evt_set;
    irq_ev[IRQ_FRZ_BIT] = ctrl[CTRL_DIAG_BIT] & int_evt_set[INT_RXERR_BIT] & ~int_evt[INT_RXERR_BIT];
    next_irq_stat = (rd && sel == REG_ISTAT) ? RST_BYTE : irq_stat;
    next_irq_stat = next_irq_stat | irq_ev;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat <= RST_BYTE;
    else
      irq_stat <= next_irq_stat;
  end

  assign irq = |(irq_stat & irq_mask);

  // ==========================================================
  // read data, captured in the setup cycle
  always_comb
  begin
    read_mux = RST_BYTE;
    unique case (sel)
      REG_EVT: read_mux = evt;
      REG_INT: read_mux = int_evt;
      REG_STAT: read_mux = sb.status; // RL5
      REG_CMP: read_mux = cmp;
      REG_CTRL: read_mux = ctrl;
      REG_ISTAT: read_mux = irq_stat;
      REG_IMASK: read_mux = irq_mask;
      REG_NONE: read_mux = RST_BYTE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= RST_WORD;
    else if (setup && !pwrite)
      prdata <= {24'h00_0000, read_mux};
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_cmp_read_load: assert property ( // RL1
    rd && latch_hit && !(wr && sel == REG_CMP)
    |=> cmp == $past(prdata[7:0])
  ) else $error("compare not loaded from latch read");

  a_cmp_direct_wr: assert property ( // RL2
    wr && sel == REG_CMP |=> cmp == $past(pwdata[7:0])
  ) else $error("compare direct write lost");

  a_cond_write_evt: assert property ( // RL3
    wr && sel == REG_EVT && cond && evt_set == 8'h00
    |=> evt == (($past(evt) & ($past(evt) ^ $past(cmp)))
               | ($past(pwdata[7:0]) & ~($past(evt) ^ $past(cmp))))
  ) else $error("conditional write changed a mismatching bit");

  a_cond_write_int: assert property ( // RL3
    wr && sel == REG_INT && cond && int_evt_set == 8'h00
    && ((int_evt ^ cmp) != 8'h00)
    |=> (int_evt & $past(int_evt ^ cmp)) == ($past(int_evt) & $past(int_evt ^ cmp))
  ) else $error("mismatching internal latch bit altered");

  a_set_wins: assert property (
    evt_set != 8'h00 |=> (evt & $past(evt_set)) == $past(evt_set)
  ) else $error("event lost to a clear");

  a_status_hold: assert property ( // RL4
    setup && sel == REG_STAT ##1 access && sel == REG_STAT
    |-> $stable(sb.status)
  ) else $error("status moved during access");

  a_status_read: assert property ( // RL5
    setup && !pwrite && sel == REG_STAT
    |=> prdata == {24'h00_0000, $past(sb.status)} && !pslverr
  ) else $error("status read mismatch");

  a_status_wr_ign: assert property ( // RL5
    wr && sel == REG_STAT
    |=> $stable(cmp) && $stable(ctrl) && $stable(irq_mask)
  ) else $error("status write had an effect");

  a_diag_freeze: assert property ( // RL6
    sb.diag && sb.err_bit ##1 sb.diag && sb.err_bit |-> $stable(sb.status)
  ) else $error("status not frozen on error");

  a_status_track: assert property ( // RL7
    !sb.hold && !(sb.diag && sb.err_bit)
    |=> sb.status[STAT_RESTRICTED_TOKEN_FLAG_BIT] == $past(rx_restricted)
  ) else $error("restricted flag not tracked");

  a_rx_fields: assert property ( // RL8
    !sb.hold && !(sb.diag && sb.err_bit)
    |=> sb.status[STAT_RS_LSB +: 3] == $past(rx_state)
        && sb.status[STAT_RTS_LSB +: 3] == $past(rx_timing)
  ) else $error("state fields not tracked");

  a_reserved_zero: assert property ( // RL10
    sb.status[STAT_RES_BIT] == 1'b0
  ) else $error("reserved status bit set");

  a_irq_level: assert property (
    irq == |(irq_stat & irq_mask)
    and (irq_ev != 8'h00 |=> (irq_stat & $past(irq_ev)) == $past(irq_ev))
  ) else $error("interrupt status or level wrong");

  a_unmapped_err: assert property (
    access && sel == REG_NONE |-> pslverr && pready
  ) else $error("unmapped access not flagged");

  a_plain_wr_evt: assert property ( // RL3
    wr && sel == REG_EVT && !cond
    |=> evt == ($past(pwdata[7:0]) | $past(evt_set))
  ) else $error("plain latch write not applied");

  a_plain_wr_int: assert property ( // RL3
    wr && sel == REG_INT && !cond
    |=> int_evt == ($past(pwdata[7:0]) | $past(int_evt_set))
  ) else $error("plain internal latch write not applied");

  a_evt_hold: assert property (
    !(wr && sel == REG_EVT) && evt_set == 8'h00 |=> $stable(evt)
  ) else $error("event latch moved without cause");

  a_istat_clear: assert property (
    rd && sel == REG_ISTAT |=> irq_stat == $past(irq_ev)
  ) else $error("interrupt status not cleared by read");

  a_ctrl_wr: assert property (
    wr && sel == REG_CTRL |=> ctrl == {7'h00, $past(pwdata[CTRL_DIAG_BIT])}
  ) else $error("control write lost");

  a_idle_quiet: assert property (
    !access |-> !pready && !pslverr
  ) else $error("ready or error outside access");

  a_rdata_upper: assert property (
    prdata[31:8] == 24'h00_0000
  ) else $error("upper read data not zero");

  c_cond_partial: cover property (
    wr && sel == REG_EVT && cond && (evt ^ cmp) != 8'h00 && (evt ^ cmp) != 8'hff
  );

  c_read_then_clear: cover property (
    rd && sel == REG_EVT ##[1:20] wr && sel == REG_EVT && cond
  );

  c_freeze: cover property (
    sb.diag && sb.err_bit ##[1:50] !sb.err_bit
  );

  c_irq_raise: cover property (
    !irq ##1 irq
  );

  c_int_cond_partial: cover property (
    wr && sel == REG_INT && cond && (int_evt ^ cmp) != 8'h00
  );

endmodule : rcw_top

// ---- verification/tb.sv ----
// self-checking bench for the conditional-write and receiver status register bank
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    num_checks++; \
    if ((a) !== (b)) \
    begin \
      fails++; \
      $display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); \
    end \
  end
module tb
  import rcw_pkg::*;
;
  // ==========================================================
  // clock, reset, design inputs and outputs, bench variables
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [7:0] evt_set = 8'h00;
  logic [7:0] int_evt_set = 8'h00;
  logic rx_restricted = 1'b0;
  logic [2:0] rx_state = 3'h0;
  logic [2:0] rx_timing = 3'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [31:0] rd;
  logic err;
  int fails = 0;
  int num_checks = 0;

  always #12.5 pclk = ~pclk;

  rcw_top uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .evt_set(evt_set), .int_evt_set(int_evt_set), .rx_restricted(rx_restricted),
    .rx_state(rx_state), .rx_timing(rx_timing), .irq(irq)
  );

  // ==========================================================
  // shared tasks
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  // one apb transfer; read data and error taken at the edge with pready high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      fails++;
      wrap_up();
    end
  endtask : apb

  task automatic pulse(input logic [7:0] e, input logic [7:0] ie);
    @(posedge pclk);
    evt_set <= e;
    int_evt_set <= ie;
    @(posedge pclk);
    evt_set <= 8'h00;
    int_evt_set <= 8'h00;
    repeat (2) @(posedge pclk);
  endtask : pulse

  task automatic set_rx(input logic r, input logic [2:0] s, input logic [2:0] t);
    @(posedge pclk);
    rx_restricted <= r;
    rx_state <= s;
    rx_timing <= t;
    repeat (2) @(posedge pclk);
  endtask : set_rx

  // ==========================================================
  // scenarios
  task automatic t_reset();
    apb(1'b0, ADDR_EVT, 32'h0);
    `CHK(rd, RST_WORD)
    apb(1'b0, ADDR_CMP, 32'h0);
    `CHK(rd, RST_WORD)
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK(rd, RST_WORD)
    `CHK(irq, 1'b0)
    $display("test reset done");
  endtask : t_reset

  task automatic t_cond_write();
    pulse(8'ha5, 8'h00);
    `CHK(irq, 1'b0)
    apb(1'b0, ADDR_EVT, 32'h0);
    `CHK(rd, 32'h0000_00a5)
    apb(1'b0, ADDR_CMP, 32'h0);
    `CHK(rd, 32'h0000_00a5)
    pulse(8'h0a, 8'h00);
    apb(1'b1, ADDR_EVT, 32'h0000_0000);
    apb(1'b0, ADDR_EVT, 32'h0);
    `CHK(rd, 32'h0000_000a)
    apb(1'b1, ADDR_CMP, 32'h0000_003c);
    apb(1'b0, ADDR_CMP, 32'h0);
    `CHK(rd, 32'h0000_003c)
    apb(1'b1, 12'h100, 32'h0000_0081);
    apb(1'b0, ADDR_EVT, 32'h0);
    `CHK(rd, 32'h0000_0081)
    $display("test conditional write done");
  endtask : t_cond_write

  task automatic t_status();
    logic [7:0] exp;
    for (int i = 0; i < 8; i++)
    begin
      set_rx(i[0], 3'(i), 3'(7 - i));
      exp = {i[0], 3'(i), 1'b0, 3'(7 - i)};
      apb(1'b0, ADDR_STAT, 32'h0);
      `CHK(rd, {24'h0, exp})
    end
    apb(1'b1, ADDR_STAT, 32'hffff_ffff);
    `CHK(err, 1'b0)
    apb(1'b0, ADDR_STAT, 32'h0);
    `CHK(rd, {24'h0, exp})
    $display("test status done");
  endtask : t_status

  task automatic t_freeze();
    apb(1'b0, ADDR_ISTAT, 32'h0);
    apb(1'b1, ADDR_IMASK, 32'h0000_0004);
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    set_rx(1'b1, 3'h2, 3'h3);
    pulse(8'h00, 8'h01);
    `CHK(irq, 1'b1)
    set_rx(1'b0, 3'h5, 3'h1);
    apb(1'b0, ADDR_STAT, 32'h0);
    `CHK(rd, 32'h0000_00a3)
    apb(1'b0, ADDR_ISTAT, 32'h0);
    `CHK(rd, 32'h0000_0006)
    @(posedge pclk);
    `CHK(irq, 1'b0)
    apb(1'b0, ADDR_INT, 32'h0);
    `CHK(rd, 32'h0000_0001)
    pulse(8'h00, 8'h02);
    apb(1'b1, ADDR_INT, 32'h0000_0000);
    apb(1'b0, ADDR_INT, 32'h0);
    `CHK(rd, 32'h0000_0002)
    apb(1'b1, 12'h104, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    apb(1'b0, ADDR_STAT, 32'h0);
    `CHK(rd, 32'h0000_0051)
    $display("test freeze done");
  endtask : t_freeze

  task automatic t_unmapped();
    apb(1'b1, 12'h020, 32'h0000_00ff);
    `CHK(err, 1'b1)
    apb(1'b0, 12'h020, 32'h0);
    `CHK(err, 1'b1)
    `CHK(rd, RST_WORD)
    apb(1'b0, ADDR_CMP, 32'h0);
    `CHK(err, 1'b0)
    `CHK(rd, 32'h0000_0002)
    $display("test unmapped done");
  endtask : t_unmapped

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_cond_write();
    t_status();
    t_freeze();
    t_unmapped();
    wrap_up();
  end
endmodule : tb
